//--- src/output_compare_timer.sv
/*
 * Output compare timer: 16-bit up counter, four compare registers, four wave pins.
 * Assumes a register master per the plain strobe port and a count_source beside it.
 */
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
`include "oc_timer_defs.svh"
// Functional notes
// [R01] Counter advances on selected count source
// [R02] Clear-select 0: free run, 65536 period
// [R03] Clear-select 1: reload zero on A match
// [R04] Writing start bit 1 starts counting
// [R05] Writing start bit 0 stops counting
// [R06] Stopped: pins and counter hold values
// [R07] Any compare match raises a request
// [R08] Counter overflow raises a request
// [R09] Each pin is port or compare output
// [R10] External pin: port, cutoff or interrupt
// [R11] Counter read returns current count
// [R12] Counter is writable by software
// [R13] Match drives pin low, high or toggle
// [R14] Initial level from start until match
// [R15] Clear event: overflow or A match
// [R16] Optional buffered compare for A and B
// [R17] Works as internal timer without outputs
// [R18] Match puts chosen level on that pin
// [R19] Buffer bits turn C, D into buffers
// [R20] 16-bit wrap sets visible overflow flag
// [R21] Active cutoff forces pins to cutoff state; the code forces only pins in compare output mode, port pins keep port_dat
module output_compare_timer #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   nrst_i,
    // Register port
    input  wire logic [`OCT_ADDR_W-1:0] addr_i,
    input  wire logic [`OCT_DATA_W-1:0] wr_data_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic      [`OCT_DATA_W-1:0] rd_data_o,
    // Count sources and external interrupt pin
    input  wire logic                   ext_count_clock_pin_i,
    input  wire logic                   osc_40mhz_source_i,
    input  wire logic                   ext_irq_zero_pin_i,
    // Wave pins
    input  wire logic [3:0]             wave_pin_i,
    output logic      [3:0]             wave_pin_o,
    output logic      [3:0]             wave_pin_oe_n_o,
    // Request pulses
    output logic      [3:0]             match_req_o,
    output logic                        ovf_req_o,
    output logic                        ext_irq_req_o
);
    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    count_src_if src_link ();

    logic                           start;
    logic                           buf_c;
    logic                           buf_d;
    logic                           clear_sel;
    oc_timer_pkg::src_sel_t         ck_sel;
    logic [3:0]                     init_lvl;
    logic [7:0]                     act;
    logic [3:0]                     oc_en;
    logic [3:0]                     port_dir;
    logic [3:0]                     port_dat;
    oc_timer_pkg::ext_mode_t        ext_mode;
    logic [7:0]                     cut;
    logic [3:0]                     match_flag;
    logic                           ovf_flag;
    logic                           ext_flag;
    logic [CNT_W-1:0]               count;
    logic [CNT_W-1:0]               gr [4];
    logic [3:0]                     wave_lvl;
    logic [2:0]                     irq_s;
    logic [3:0]                     pin_s1;
    logic [3:0]                     pin_s2;
    logic [15:0]                    wsel;
    logic                           tick_en;
    logic [3:0]                     match_ev;
    logic                           clear_now;
    logic                           wrap_ev;
    logic                           ext_ev;
    logic                           cut_active;
    logic                           start_pulse;
    logic [`OCT_DATA_W-1:0]         next_rd;

    function automatic logic [1:0] field2(input logic [7:0] v, input int idx);
        return v[2*idx +: 2];
    endfunction

    function automatic logic apply_act(input oc_timer_pkg::match_act_t a, input logic cur);
        case (a)
            oc_timer_pkg::ACT_LOW:    return 1'b0;
            oc_timer_pkg::ACT_HIGH:   return 1'b1;
            oc_timer_pkg::ACT_TOGGLE: return ~cur;
            default:                  return cur;
        endcase
    endfunction

    count_source u_src (
        .clk_i                 (clk_i),
        .nrst_i                (nrst_i),
        .ext_count_clock_pin_i (ext_count_clock_pin_i),
        .osc_40mhz_source_i    (osc_40mhz_source_i),
        .src                   (src_link.source)
    );
    assign src_link.sel = ck_sel;

    assign wsel        = wr_i ? (16'h0001 << addr_i) : 16'h0000;
    assign tick_en     = start & src_link.tick; // [R01]
    assign start_pulse = wsel[`OCT_OFS_MODE] & wr_data_i[`OCT_MODE_START] & ~start;

    // Buffering C or D removes it from comparison
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            match_ev[i] = tick_en && (count == gr[i]); // [R07]
        end
        match_ev[2] = match_ev[2] & ~buf_c; // [R19]
        match_ev[3] = match_ev[3] & ~buf_d; // [R19]
    end

    assign clear_now = clear_sel & match_ev[0]; // [R03] [R15]
    // Clear at A takes the wrap's place, so no overflow is seen then
    assign wrap_ev   = tick_en & (count == CNT_MAX) & ~clear_now; // [R08] [R20]

    // Control registers
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            start     <= 1'b0;
            buf_c     <= 1'b0;
            buf_d     <= 1'b0;
            clear_sel <= 1'b0;
            ck_sel    <= oc_timer_pkg::SRC_F1;
            init_lvl  <= 4'h0;
            act       <= `OCT_RST_ACT;
            oc_en     <= 4'h0;
            port_dir  <= 4'h0;
            port_dat  <= 4'h0;
            ext_mode  <= oc_timer_pkg::EXT_PORT;
            cut       <= `OCT_RST_CUT;
        end else begin
            if (wsel[`OCT_OFS_MODE]) begin
                start <= wr_data_i[`OCT_MODE_START]; // [R04] [R05]
                buf_c <= wr_data_i[`OCT_MODE_BUFC]; // [R16]
                buf_d <= wr_data_i[`OCT_MODE_BUFD]; // [R16]
            end
            if (wsel[`OCT_OFS_CTRL]) begin
                clear_sel <= wr_data_i[`OCT_CTRL_CLR]; // [R15]
                ck_sel    <= oc_timer_pkg::src_sel_t'(wr_data_i[`OCT_CTRL_CKSEL +: 3]);
                init_lvl  <= wr_data_i[`OCT_CTRL_INIT +: 4];
            end
            if (wsel[`OCT_OFS_ACT]) begin
                act <= wr_data_i[7:0];
            end
            if (wsel[`OCT_OFS_PINS]) begin
                oc_en    <= wr_data_i[`OCT_PINS_OCEN +: 4]; // [R09]
                port_dir <= wr_data_i[`OCT_PINS_DIR +: 4];
                port_dat <= wr_data_i[`OCT_PINS_DAT +: 4];
            end
            if (wsel[`OCT_OFS_EXT]) begin
                ext_mode <= oc_timer_pkg::ext_mode_t'(wr_data_i[`OCT_EXT_MODE +: 2]); // [R10]
                cut      <= wr_data_i[`OCT_EXT_CUT +: 8];
            end
        end
    end

    // Counter: software write beats a tick in the same cycle
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            count <= '0;
        end else if (wsel[`OCT_OFS_COUNT]) begin
            count <= wr_data_i[CNT_W-1:0]; // [R12]
        end else if (tick_en) begin
            count <= clear_now ? '0 : count + 1'b1; // [R02] [R03]
        end
    end

    // Compare registers, with buffer transfer on the A and B matches
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < 4; i++) begin
                gr[i] <= `OCT_RST_GR;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wsel[`OCT_OFS_GRA + i]) begin
                    gr[i] <= wr_data_i[CNT_W-1:0];
                end
            end
            if (buf_c && match_ev[0] && !wsel[`OCT_OFS_GRA]) begin
                gr[0] <= gr[2]; // [R16] [R19]
            end
            if (buf_d && match_ev[1] && !wsel[`OCT_OFS_GRA + 1]) begin
                gr[1] <= gr[3]; // [R16] [R19]
            end
        end
    end

    // Wave levels change only at start or on a match, so a stop holds them
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            wave_lvl <= 4'h0;
        end else if (start_pulse) begin
            wave_lvl <= init_lvl; // [R14]
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (match_ev[i]) begin
                    wave_lvl[i] <= apply_act(oc_timer_pkg::match_act_t'(field2(act, i)),
                                             wave_lvl[i]); // [R13] [R18] [R06]
                end
            end
        end
    end

    // Synchronisers for the external interrupt pin and port inputs
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            irq_s  <= 3'h7;
            pin_s1 <= 4'h0;
            pin_s2 <= 4'h0;
        end else begin
            irq_s  <= {irq_s[1:0], ext_irq_zero_pin_i};
            pin_s1 <= wave_pin_i;
            pin_s2 <= pin_s1;
        end
    end

    // Pin is active low, as an interrupt-style cutoff input
    assign cut_active = (ext_mode == oc_timer_pkg::EXT_CUTOFF) & ~irq_s[1]; // [R10] [R21]
    assign ext_ev     = (ext_mode == oc_timer_pkg::EXT_IRQ) & ~irq_s[1] & irq_s[2]; // [R10]

    // Pin drivers
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            wave_pin_o      <= 4'h0;
            wave_pin_oe_n_o <= 4'hF;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (!oc_en[i]) begin
                    wave_pin_o[i]      <= port_dat[i]; // [R09]
                    wave_pin_oe_n_o[i] <= ~port_dir[i];
                end else if (cut_active) begin
                    case (oc_timer_pkg::cut_state_t'(field2(cut, i)))
                        oc_timer_pkg::CUT_LOW: begin
                            wave_pin_o[i]      <= 1'b0; // [R21]
                            wave_pin_oe_n_o[i] <= 1'b0;
                        end
                        oc_timer_pkg::CUT_HIGH: begin
                            wave_pin_o[i]      <= 1'b1; // [R21]
                            wave_pin_oe_n_o[i] <= 1'b0;
                        end
                        default: begin
                            wave_pin_o[i]      <= 1'b0; // [R21]
                            wave_pin_oe_n_o[i] <= 1'b1;
                        end
                    endcase
                end else begin
                    wave_pin_o[i]      <= wave_lvl[i]; // [R18]
                    wave_pin_oe_n_o[i] <= 1'b0;
                end
            end
        end
    end

    // Status flags: write one to clear, a same-cycle event wins
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            match_flag <= 4'h0;
            ovf_flag   <= 1'b0;
            ext_flag   <= 1'b0;
        end else begin
            match_flag <= (match_flag & ~({4{wsel[`OCT_OFS_STAT]}}
                          & wr_data_i[`OCT_STAT_MATCH +: 4])) | match_ev; // [R07] [R17]
            ovf_flag   <= (ovf_flag & ~(wsel[`OCT_OFS_STAT] & wr_data_i[`OCT_STAT_OVF]))
                          | wrap_ev; // [R08] [R20]
            ext_flag   <= (ext_flag & ~(wsel[`OCT_OFS_STAT] & wr_data_i[`OCT_STAT_EXT]))
                          | ext_ev;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            match_req_o   <= 4'h0;
            ovf_req_o     <= 1'b0;
            ext_irq_req_o <= 1'b0;
        end else begin
            match_req_o   <= match_ev; // [R07] [R17]
            ovf_req_o     <= wrap_ev; // [R08]
            ext_irq_req_o <= ext_ev;
        end
    end

    // Read mux
    always_comb begin
        next_rd = '0;
        case (addr_i)
            `OCT_OFS_MODE:  next_rd = {13'h0000, buf_d, buf_c, start};
            `OCT_OFS_CTRL:  next_rd = {8'h00, init_lvl, ck_sel, clear_sel};
            `OCT_OFS_ACT:   next_rd = {8'h00, act};
            `OCT_OFS_PINS:  next_rd = {pin_s2, port_dat, port_dir, oc_en};
            `OCT_OFS_STAT:  next_rd = {10'h000, ext_flag, ovf_flag, match_flag};
            `OCT_OFS_EXT:   next_rd = {4'h0, cut, 2'h0, ext_mode};
            `OCT_OFS_COUNT: next_rd = `OCT_DATA_W'(count); // [R11]
            4'h8, 4'h9, 4'hA, 4'hB: next_rd = `OCT_DATA_W'(gr[addr_i[1:0]]);
            default:        next_rd = '0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rd_data_o <= '0;
        end else begin
            rd_data_o <= rd_i ? next_rd : '0; // [R11]
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_start_write;
        start_pulse;
    endsequence

    sequence s_started_init;
        start && (wave_lvl == $past(init_lvl));
    endsequence

    a_count_advance: assert property (tick_en && !clear_now && !wsel[`OCT_OFS_COUNT]
        |=> count == CNT_W'($past(count) + 1'b1)) else $error("count missed a step"); // [R02]
    a_clear_on_a: assert property (clear_now && !wsel[`OCT_OFS_COUNT]
        |=> count == '0) else $error("no clear on A match"); // [R03]
    a_stop_hold: assert property (!start && !wsel[`OCT_OFS_COUNT] && !start_pulse
        |=> $stable(count) && $stable(wave_lvl)) else $error("stopped timer moved"); // [R06]
    a_start_init: assert property (s_start_write |=> s_started_init)
        else $error("initial level not applied"); // [R14]
    a_match_flag: assert property (match_ev[0]
        |=> match_flag[0] && match_req_o[0]) else $error("match A not flagged"); // [R07]
    a_ovf_flag: assert property (wrap_ev |=> ovf_flag && ovf_req_o && count == '0)
        else $error("overflow not flagged"); // [R20]
    a_toggle_a: assert property (match_ev[0] && !start_pulse && field2(act, 0) == 2'h3
        |=> wave_lvl[0] != $past(wave_lvl[0])) else $error("toggle A failed"); // [R13]
    a_buffer_xfer: assert property (buf_c && match_ev[0] && !wsel[`OCT_OFS_GRA]
        |=> gr[0] == $past(gr[2])) else $error("buffer C not moved to A"); // [R19]
    a_cutoff_low: assert property (cut_active && oc_en[0] && field2(cut, 0) == 2'h1
        |=> !wave_pin_o[0] && !wave_pin_oe_n_o[0]) else $error("cutoff low failed"); // [R21]
    a_read_count: assert property (rd_i && addr_i == `OCT_OFS_COUNT
        |=> rd_data_o == `OCT_DATA_W'($past(count))) else $error("bad count read"); // [R11]
endmodule

//--- src/oc_timer_defs.svh
/*
 * Offsets, field positions, reset values and prescaler counts of the output compare timer.
 * Assumes a word-addressed register port with a 4-bit address and 16-bit data.
 */
`ifndef OC_TIMER_DEFS_SVH
`define OC_TIMER_DEFS_SVH

`define OCT_ADDR_W      4
`define OCT_DATA_W      16

`define OCT_OFS_MODE    4'h0
`define OCT_OFS_CTRL    4'h1
`define OCT_OFS_ACT     4'h2
`define OCT_OFS_PINS    4'h3
`define OCT_OFS_STAT    4'h4
`define OCT_OFS_EXT     4'h5
`define OCT_OFS_COUNT   4'h6
`define OCT_OFS_GRA     4'h8

`define OCT_MODE_START  0
`define OCT_MODE_BUFC   1
`define OCT_MODE_BUFD   2
`define OCT_CTRL_CLR    0
`define OCT_CTRL_CKSEL  1
`define OCT_CTRL_INIT   4
`define OCT_PINS_OCEN   0
`define OCT_PINS_DIR    4
`define OCT_PINS_DAT    8
`define OCT_PINS_IN     12
`define OCT_STAT_MATCH  0
`define OCT_STAT_OVF    4
`define OCT_STAT_EXT    5
`define OCT_EXT_MODE    0
`define OCT_EXT_CUT     4

`define OCT_RST_GR      16'hFFFF
`define OCT_RST_ACT     8'h00
`define OCT_RST_CUT     8'h00

`define OCT_PRE_W       5
`define OCT_MASK_F2     5'h01
`define OCT_MASK_F4     5'h03
`define OCT_MASK_F8     5'h07
`define OCT_MASK_F32    5'h1F

`endif

//--- src/oc_timer_pkg.sv
/*
 * Types shared by the output compare timer and its count source.
 * Assumes the defines header is included by the files that need numbers.
 */
package oc_timer_pkg;
    typedef enum logic [1:0] {ACT_NONE, ACT_LOW, ACT_HIGH, ACT_TOGGLE} match_act_t;
    typedef enum logic [1:0] {EXT_PORT, EXT_CUTOFF, EXT_IRQ, EXT_RSVD} ext_mode_t;
    typedef enum logic [1:0] {CUT_FLOAT, CUT_LOW, CUT_HIGH, CUT_RSVD} cut_state_t;
    typedef enum logic [2:0] {
        SRC_F1, SRC_F2, SRC_F4, SRC_F8, SRC_F32, SRC_OSC, SRC_EXT, SRC_OFF
    } src_sel_t;
endpackage

//--- src/count_src_if.sv
/*
 * Carrier between the timer core and its count source selector.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface count_src_if;
    oc_timer_pkg::src_sel_t sel;
    logic                   tick;
    modport source (input sel, output tick);
    modport sink   (output sel, input tick);
endinterface

//--- src/count_source.sv
/*
 * Count source: divided system clocks, oscillator edges or external pin edges.
 * Assumes the oscillator and pin are asynchronous and far slower than clk_i after sync.
 */
`timescale 1ns/10ps
`include "oc_timer_defs.svh"
module count_source (
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   nrst_i,
    // Raw count inputs
    input  wire logic                   ext_count_clock_pin_i,
    input  wire logic                   osc_40mhz_source_i,
    // To the timer core
    count_src_if.source                 src
);
    logic [`OCT_PRE_W-1:0] pre;
    logic [2:0]            ext_s;
    logic [2:0]            osc_s;
    logic                  next_tick;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pre <= '0;
        end else begin
            pre <= pre + 1'b1;
        end
    end

    // Third stage only remembers the previous synced level for edge detect
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ext_s <= 3'h0;
            osc_s <= 3'h0;
        end else begin
            ext_s <= {ext_s[1:0], ext_count_clock_pin_i};
            osc_s <= {osc_s[1:0], osc_40mhz_source_i};
        end
    end

    always_comb begin
        case (src.sel)
            oc_timer_pkg::SRC_F1:  next_tick = 1'b1;
            oc_timer_pkg::SRC_F2:  next_tick = (pre & `OCT_MASK_F2) == `OCT_MASK_F2;
            oc_timer_pkg::SRC_F4:  next_tick = (pre & `OCT_MASK_F4) == `OCT_MASK_F4;
            oc_timer_pkg::SRC_F8:  next_tick = (pre & `OCT_MASK_F8) == `OCT_MASK_F8;
            oc_timer_pkg::SRC_F32: next_tick = (pre & `OCT_MASK_F32) == `OCT_MASK_F32;
            // Oscillator above clk_i rate aliases; usable only as a slow gated source
            oc_timer_pkg::SRC_OSC: next_tick = osc_s[1] & ~osc_s[2]; // [R01]
            oc_timer_pkg::SRC_EXT: next_tick = ext_s[1] & ~ext_s[2]; // [R01]
            default:               next_tick = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            src.tick <= 1'b0;
        end else begin
            src.tick <= next_tick; // [R01]
        end
    end
endmodule

//--- verif/pin_load.sv
/*
 * Load model on the four wave pins, one pull-up per line.
 * Assumes active-low output enables from the timer.
 */
`timescale 1ns/10ps
module pin_load (
    // From the timer
    input  wire logic [3:0] level_i,
    input  wire logic [3:0] oe_n_i,
    // Line levels back to the timer
    output logic      [3:0] line_o
);
    // Released line is pulled up, never left at its last value
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            line_o[k] = oe_n_i[k] ? 1'b1 : level_i[k];
        end
    end
endmodule

//--- verif/output_compare_timer_tb_top.sv
/*
 * Self-checking bench for the output compare timer.
 * Assumes the plain strobe register port and a pull-up load on the pins.
 */
`timescale 1ns/10ps
`include "oc_timer_defs.svh"
module output_compare_timer_tb_top;
    logic        clk = 1'b0;
    logic        nrst_n = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] rdata;
    logic        osc = 1'b0;
    logic        irq_pin_n = 1'b1;
    logic [3:0]  line;
    logic [3:0]  pin_o;
    logic [3:0]  pin_oe_n;
    logic [3:0]  mreq;
    logic        ovf;
    logic        xreq;
    logic [5:0]  ev;
    int          errors = 0;
    int          cmp_count = 0;

    assign ev = {xreq, ovf, mreq};
    always #20 clk = ~clk;
    // Offset keeps source edges clear of clock edges; 5 cycles a period
    initial begin
        #5;
        forever #100 osc = ~osc;
    end

    output_compare_timer DUT (
        .clk_i(clk), .nrst_i(nrst_n), .addr_i(addr), .wr_data_i(wdata),
        .wr_i(wr), .rd_i(rd), .rd_data_o(rdata), .ext_count_clock_pin_i(osc),
        .osc_40mhz_source_i(osc), .ext_irq_zero_pin_i(irq_pin_n),
        .wave_pin_i(line), .wave_pin_o(pin_o), .wave_pin_oe_n_o(pin_oe_n),
        .match_req_o(mreq), .ovf_req_o(ovf), .ext_irq_req_o(xreq)
    );
    pin_load LOAD (.level_i(pin_o), .oe_n_i(pin_oe_n), .line_o(line));

    task automatic test_done();
        if (errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Cycles from now to the next pulse of event i
    task automatic wait_ev(input int i, input int lim, output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (ev[i] !== 1'b1 && n < lim);
        if (n >= lim) begin
            errors++;
            $display("unexpected event %0d wait: expected pulse, seen none", i);
        end
    endtask

    task automatic t_reset();
        logic [15:0] d;
        rd_reg(`OCT_OFS_COUNT, d);
        chk("count after reset", 16'h0000, d);
        rd_reg(`OCT_OFS_GRA, d);
        chk("compare a after reset", 16'hFFFF, d);
        wr_reg(4'h7, 16'h1234);
        rd_reg(4'h7, d);
        chk("unmapped read", 16'h0000, d);
        chk("enables after reset", 16'h000F, {12'h000, pin_oe_n});
    endtask

    task automatic t_start_stop();
        logic [15:0] c1;
        logic [15:0] c2;
        wr_reg(`OCT_OFS_COUNT, 16'h1234);
        rd_reg(`OCT_OFS_COUNT, c1);
        chk("count written", 16'h1234, c1);
        wr_reg(`OCT_OFS_MODE, 16'h0001);
        settle(6);
        wr_reg(`OCT_OFS_MODE, 16'h0000);
        rd_reg(`OCT_OFS_COUNT, c1);
        settle(4);
        rd_reg(`OCT_OFS_COUNT, c2);
        // Eight f1 ticks: from the edge after start is set up to the stop edge
        chk("count advanced", 16'h123C, c1);
        chk("count held", c1, c2);
    endtask

    // Clear on A match, A=4: period is 5 ticks of each source; outputs off
    task automatic t_period();
        int div[7] = '{1, 2, 4, 8, 32, 5, 5};
        int n;
        for (int s = 0; s < 7; s++) begin
            wr_reg(`OCT_OFS_MODE, 16'h0000);
            wr_reg(`OCT_OFS_CTRL, 16'(1 | (s << 1)));
            wr_reg(`OCT_OFS_GRA, 16'h0004);
            wr_reg(`OCT_OFS_COUNT, 16'h0000);
            wr_reg(`OCT_OFS_MODE, 16'h0001);
            wait_ev(0, 1000, n);
            wait_ev(0, 1000, n);
            chk("a match period", 16'(5 * div[s]), 16'(n));
        end
    endtask

    task automatic t_overflow();
        logic [15:0] d;
        int n;
        wr_reg(`OCT_OFS_MODE, 16'h0000);
        wr_reg(`OCT_OFS_CTRL, 16'h0000);
        wr_reg(`OCT_OFS_COUNT, 16'hFFF0);
        wr_reg(`OCT_OFS_STAT, 16'h00FF);
        wr_reg(`OCT_OFS_MODE, 16'h0001);
        wait_ev(4, 100, n);
        wait_ev(4, 70000, n);
        chk("free run period", 16'h0000, 16'(n - 65536));
        rd_reg(`OCT_OFS_STAT, d);
        chk("overflow flag", 16'h0010, d & 16'h0010);
    endtask

    // A toggle, B high, C low, D none; initial levels D,C high
    task automatic t_match_pins();
        logic [15:0] d;
        int n;
        wr_reg(`OCT_OFS_MODE, 16'h0000);
        wr_reg(`OCT_OFS_CTRL, 16'h00C0);
        wr_reg(`OCT_OFS_ACT, 16'h001B);
        for (int g = 0; g < 4; g++) wr_reg(4'(`OCT_OFS_GRA + g), 16'h0020);
        wr_reg(`OCT_OFS_PINS, 16'h000F);
        wr_reg(`OCT_OFS_COUNT, 16'h0000);
        wr_reg(`OCT_OFS_MODE, 16'h0001);
        settle(3);
        chk("initial levels", 16'h000C, {12'h000, pin_o});
        wait_ev(0, 100, n);
        chk("match requests", 16'h000F, {12'h000, mreq});
        settle(2);
        chk("levels after match", 16'h000B, {12'h000, pin_o});
        chk("pins driven", 16'h0000, {12'h000, pin_oe_n});
        wr_reg(`OCT_OFS_MODE, 16'h0000);
        // A running counter would reach the A match inside the wait
        wr_reg(`OCT_OFS_COUNT, 16'h0010);
        settle(80);
        chk("levels held", 16'h000B, {12'h000, pin_o});
        rd_reg(`OCT_OFS_STAT, d);
        chk("match flags", 16'h000F, d & 16'h000F);
    endtask

    task automatic t_ext_pin();
        int n;
        // Cutoff states: A low, B high, C low, D high
        wr_reg(`OCT_OFS_EXT, 16'h0991);
        irq_pin_n <= 1'b0;
        settle(6);
        chk("cutoff levels", 16'h00A0, {8'h00, pin_o, pin_oe_n});
        wr_reg(`OCT_OFS_EXT, 16'h0001);
        settle(6);
        chk("cutoff float", 16'h000F, {12'h000, pin_oe_n});
        wr_reg(`OCT_OFS_EXT, 16'h0002);
        irq_pin_n <= 1'b1;
        repeat (6) @(posedge clk);
        irq_pin_n <= 1'b0;
        wait_ev(5, 20, n);
        wr_reg(`OCT_OFS_EXT, 16'h0000);
        irq_pin_n <= 1'b1;
    endtask

    task automatic t_port_buffer();
        logic [15:0] d;
        int n;
        wr_reg(`OCT_OFS_PINS, 16'h0AF0);
        rd_reg(`OCT_OFS_PINS, d);
        settle(3);
        chk("port out", 16'h000A, {12'h000, pin_o});
        rd_reg(`OCT_OFS_PINS, d);
        chk("port readback", 16'hAAF0, d);
        wr_reg(`OCT_OFS_PINS, 16'h0A00);
        settle(4);
        rd_reg(`OCT_OFS_PINS, d);
        chk("port released", 16'hFA00, d);
        wr_reg(`OCT_OFS_CTRL, 16'h0001);
        wr_reg(`OCT_OFS_GRA, 16'h0004);
        wr_reg(4'(`OCT_OFS_GRA + 2), 16'h0009);
        wr_reg(`OCT_OFS_COUNT, 16'h0000);
        wr_reg(`OCT_OFS_MODE, 16'h0003);
        wait_ev(0, 100, n);
        wr_reg(`OCT_OFS_MODE, 16'h0000);
        rd_reg(`OCT_OFS_GRA, d);
        chk("buffered compare a", 16'h0009, d);
    endtask

    initial begin
        #4_000_000;
        errors++;
        test_done();
    end

    initial begin
        repeat (5) @(posedge clk);
        nrst_n <= 1'b1;
        t_reset();
        t_start_stop();
        t_period();
        t_overflow();
        t_match_pins();
        t_ext_pin();
        t_port_buffer();
        test_done();
    end
endmodule
